// [design/adc_dsp_config_bank.v]
`include "adc_dsp_defines.vh"

module adc_dsp_config_bank (
	input wire ref_clk,
	input wire arst_n,
	input wire regWrEn,
	input wire regRdEn,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	output reg [7:0] regRdData,
	input wire adcPowered,
	input wire [7:0] firstChannelVolumeCode,
	input wire [7:0] secondChannelVolumeCode,
	input wire [1:0] channelActive,
	input wire [1:0] channelRangeEnhEnable,
	input wire channelGainAboveZero,
	output reg runtimeVolumeLock,
	output reg enhancedDynamicsSel,
	output reg [1:0] decimationResponse,
	output reg [2:0] decimationOneHot,
	output reg channelSummationAvg,
	output reg [1:0] highpassSelect,
	output reg highpassUseIir,
	output reg volumeGang,
	output reg [1:0] biquadCount,
	output reg [2:0] biquadEnable,
	output reg softStepEnable,
	output reg rangeEnhancerActive,
	output reg autoGainControlActive,
	output reg rangeCompressionActive,
	output reg antiClipEngaged,
	output reg [1:0] channelMute,
	output reg [7:0] firstChannelAppliedCode,
	output reg [7:0] secondChannelAppliedCode,
	output reg signed [8:0] firstChannelGainHalfDb,
	output reg signed [8:0] secondChannelGainHalfDb
);

	reg [7:0] dspConfigFirst;
	reg [7:0] dspConfigSecond;
	reg [7:0] next_regRdData;
	reg [7:0] ch2Target;
	reg volumeHold;
	reg next_rangeEnh;
	reg next_autoGain;
	reg next_compress;
	wire [7:0] volCode1;
	wire [7:0] volCode2;
	wire volMute1;
	wire volMute2;
	wire signed [8:0] volGain1;
	wire signed [8:0] volGain2;

	// the whole stored register for either mapped address, the unmapped read value elsewhere
	function [7:0] readMux;
		input [7:0] addr;
		input [7:0] first;
		input [7:0] second;
		begin
			case (addr)
				`ADC_DSP_FIRST_ADDR: readMux = first;
				`ADC_DSP_SECOND_ADDR: readMux = second;
				default: readMux = `ADC_DSP_UNMAPPED_READ;
			endcase
		end
	endfunction

	// thermometer of enabled biquad stages
	function [2:0] stageMask;
		input [1:0] count;
		begin
			case (count)
				2'h0: stageMask = 3'h0;
				2'h1: stageMask = 3'h1;
				2'h2: stageMask = 3'h3;
				default: stageMask = 3'h7;
			endcase
		end
	endfunction

	// register writes take effect at the next edge with no commit step
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dspConfigFirst <= `ADC_DSP_FIRST_RESET;
			dspConfigSecond <= `ADC_DSP_SECOND_RESET;
		end else if (regWrEn) begin
			if (regAddr == `ADC_DSP_FIRST_ADDR)
				dspConfigFirst <= regWrData;
			if (regAddr == `ADC_DSP_SECOND_ADDR)
				dspConfigSecond <= regWrData;
		end
	end

	always @* begin
		next_regRdData = regRdEn ? readMux(regAddr, dspConfigFirst, dspConfigSecond) :
			regRdData;
	end

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			regRdData <= 8'h00;
		else
			regRdData <= next_regRdData;
	end

	// dynamics mode: compression excludes the other two; enhancer/AUTO_GAIN_CONTROL need a channel enable
	always @* begin
		next_compress = dspConfigSecond[`ADC_COMPRESSION_BIT];
		next_rangeEnh = 1'b0;
		next_autoGain = 1'b0;
		if (!next_compress && (|channelRangeEnhEnable)) begin
			if (dspConfigSecond[`ADC_RANGE_GAIN_SEL_BIT])
				next_autoGain = 1'b1;
			else
				next_rangeEnh = 1'b1;
		end
	end

	// gang copies channel one's code even when channel one itself is off
	always @* begin
		ch2Target = dspConfigSecond[`ADC_VOLUME_GANG_BIT] ?
			firstChannelVolumeCode : secondChannelVolumeCode;
		volumeHold = dspConfigFirst[`ADC_RUNTIME_VOLUME_LOCK_BIT] & adcPowered;
	end

	adc_vol_resolve u_vol1 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.targetCode(firstChannelVolumeCode),
		.lockHold(volumeHold),
		.softStep(~dspConfigSecond[`ADC_SOFT_STEP_OFF_BIT]),
		.appliedCode(volCode1),
		.muted(volMute1),
		.gainHalfDb(volGain1)
	);

	adc_vol_resolve u_vol2 (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.targetCode(ch2Target),
		.lockHold(volumeHold),
		.softStep(~dspConfigSecond[`ADC_SOFT_STEP_OFF_BIT]),
		.appliedCode(volCode2),
		.muted(volMute2),
		.gainHalfDb(volGain2)
	);

	// every datapath control is re-registered so outputs come straight from flops
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			runtimeVolumeLock <= 1'b0;
			enhancedDynamicsSel <= 1'b0;
			decimationResponse <= `ADC_DECI_LINEAR;
			decimationOneHot <= 3'h1;
			channelSummationAvg <= 1'b0;
			highpassSelect <= `ADC_HPF_CUT_00025;
			highpassUseIir <= 1'b0;
			volumeGang <= 1'b0;
			biquadCount <= 2'h2;
			biquadEnable <= 3'h3;
			softStepEnable <= 1'b1;
			rangeEnhancerActive <= 1'b0;
			autoGainControlActive <= 1'b0;
			rangeCompressionActive <= 1'b0;
			antiClipEngaged <= 1'b0;
			channelMute <= 2'h0;
			firstChannelAppliedCode <= `ADC_VOL_RESET;
			secondChannelAppliedCode <= `ADC_VOL_RESET;
			firstChannelGainHalfDb <= 9'sh000;
			secondChannelGainHalfDb <= 9'sh000;
		end else begin
			runtimeVolumeLock <= dspConfigFirst[`ADC_RUNTIME_VOLUME_LOCK_BIT];
			enhancedDynamicsSel <= dspConfigFirst[`ADC_ENHANCED_DYNAMICS_BIT];
			decimationResponse <=
				dspConfigFirst[`ADC_DECIMATION_HI:`ADC_DECIMATION_LO];
			// reserved code 3 selects no filter variant; host keeps it out
			case (dspConfigFirst[`ADC_DECIMATION_HI:`ADC_DECIMATION_LO])
				`ADC_DECI_LINEAR: decimationOneHot <= 3'h1;
				`ADC_DECI_LOW_LAT: decimationOneHot <= 3'h2;
				`ADC_DECI_ULTRA_LOW: decimationOneHot <= 3'h4;
				default: decimationOneHot <= 3'h0;
			endcase
			// reserved summation codes are treated as summation off
			channelSummationAvg <= (dspConfigFirst[`ADC_SUMMATION_HI:`ADC_SUMMATION_LO]
				== `ADC_SUM_AVERAGE);
			highpassSelect <= dspConfigFirst[`ADC_HIGHPASS_HI:`ADC_HIGHPASS_LO];
			highpassUseIir <= (dspConfigFirst[`ADC_HIGHPASS_HI:`ADC_HIGHPASS_LO]
				== `ADC_HPF_IIR);
			volumeGang <= dspConfigSecond[`ADC_VOLUME_GANG_BIT];
			biquadCount <= dspConfigSecond[`ADC_BIQUAD_HI:`ADC_BIQUAD_LO];
			biquadEnable <= stageMask(dspConfigSecond[`ADC_BIQUAD_HI:`ADC_BIQUAD_LO]);
			softStepEnable <= ~dspConfigSecond[`ADC_SOFT_STEP_OFF_BIT];
			rangeEnhancerActive <= next_rangeEnh;
			autoGainControlActive <= next_autoGain;
			rangeCompressionActive <= next_compress;
			antiClipEngaged <= dspConfigSecond[`ADC_ANTI_CLIP_BIT] & channelGainAboveZero &
				(next_rangeEnh | next_autoGain | next_compress);
			// inactive channels read as muted toward the datapath
			channelMute <= {volMute2 | ~channelActive[1], volMute1 | ~channelActive[0]};
			firstChannelAppliedCode <= volCode1;
			secondChannelAppliedCode <= volCode2;
			firstChannelGainHalfDb <= volGain1;
			secondChannelGainHalfDb <= volGain2;
		end
	end

endmodule // adc_dsp_config_bank

// [design/adc_dsp_defines.vh]
`ifndef ADC_DSP_DEFINES_VH
`define ADC_DSP_DEFINES_VH

// register offsets
`define ADC_DSP_FIRST_ADDR 8'h6b
`define ADC_DSP_SECOND_ADDR 8'h6c

// reset values and the unmapped read value
`define ADC_DSP_FIRST_RESET 8'h01
`define ADC_DSP_SECOND_RESET 8'h40
`define ADC_DSP_UNMAPPED_READ 8'h00

// first processing register fields
`define ADC_RUNTIME_VOLUME_LOCK_BIT 7
`define ADC_ENHANCED_DYNAMICS_BIT 6
`define ADC_DECIMATION_HI 5
`define ADC_DECIMATION_LO 4
`define ADC_SUMMATION_HI 3
`define ADC_SUMMATION_LO 2
`define ADC_HIGHPASS_HI 1
`define ADC_HIGHPASS_LO 0

// second processing register fields
`define ADC_VOLUME_GANG_BIT 7
`define ADC_BIQUAD_HI 6
`define ADC_BIQUAD_LO 5
`define ADC_SOFT_STEP_OFF_BIT 4
`define ADC_RANGE_GAIN_SEL_BIT 3
`define ADC_RESERVED_BIT 2
`define ADC_COMPRESSION_BIT 1
`define ADC_ANTI_CLIP_BIT 0

// field codes
`define ADC_DECI_LINEAR 2'h0
`define ADC_DECI_LOW_LAT 2'h1
`define ADC_DECI_ULTRA_LOW 2'h2
`define ADC_SUM_OFF 2'h0
`define ADC_SUM_AVERAGE 2'h1
`define ADC_HPF_IIR 2'h0
`define ADC_HPF_CUT_00025 2'h1
`define ADC_HPF_CUT_002 2'h2
`define ADC_HPF_CUT_008 2'h3

// volume code map, gain in half-dB steps
`define ADC_VOL_MUTE 8'h00
`define ADC_VOL_ZERO_DB 8'hc9
`define ADC_VOL_RESET 8'hc9

`endif

// [design/adc_vol_resolve.v]
`include "adc_dsp_defines.vh"

// one channel's applied volume: lock hold, optional soft stepping, code to gain
module adc_vol_resolve (
	input wire ref_clk,
	input wire arst_n,
	input wire [7:0] targetCode,
	input wire lockHold,
	input wire softStep,
	output reg [7:0] appliedCode,
	output reg muted,
	output reg signed [8:0] gainHalfDb
);

	reg [7:0] next_appliedCode;

	always @* begin
		next_appliedCode = appliedCode;
		if (!lockHold) begin
			if (!softStep)
				next_appliedCode = targetCode;
			else if (appliedCode < targetCode)
				next_appliedCode = appliedCode + 8'h01;
			else if (appliedCode > targetCode)
				next_appliedCode = appliedCode - 8'h01;
		end
	end

	// mute and gain decode the code being loaded, so all three change on one edge
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			appliedCode <= `ADC_VOL_RESET;
			muted <= 1'b0;
			gainHalfDb <= 9'sh000;
		end else begin
			appliedCode <= next_appliedCode;
			muted <= (next_appliedCode == `ADC_VOL_MUTE);
			gainHalfDb <= $signed({1'b0, next_appliedCode}) -
				$signed({1'b0, `ADC_VOL_ZERO_DB});
		end
	end

endmodule // adc_vol_resolve

// [verif/adc_dsp_config_bank_sva.sv]
module adc_dsp_config_bank_sva (
	input wire ref_clk,
	input wire arst_n,
	input wire regWrEn,
	input wire regRdEn,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire [7:0] regRdData,
	input wire adcPowered,
	input wire runtimeVolumeLock,
	input wire [1:0] decimationResponse,
	input wire [2:0] decimationOneHot,
	input wire [1:0] highpassSelect,
	input wire highpassUseIir,
	input wire volumeGang,
	input wire [1:0] biquadCount,
	input wire [2:0] biquadEnable,
	input wire softStepEnable,
	input wire rangeEnhancerActive,
	input wire autoGainControlActive,
	input wire rangeCompressionActive,
	input wire [7:0] firstChannelAppliedCode,
	input wire signed [8:0] firstChannelGainHalfDb
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	deci_onehot_a: assert property (decimationOneHot == (decimationResponse == 2'h3 ? 3'h0 :
		3'h1 << decimationResponse)) else $error("decimation one-hot wrong");
	biquad_therm_a: assert property (biquadEnable == (3'h7 >> (2'h3 - biquadCount)))
		else $error("biquad enables wrong");
	hpf_iir_a: assert property (highpassUseIir == (highpassSelect == 2'h0))
		else $error("iir select wrong");
	comp_exclusive_a: assert property (rangeCompressionActive |->
		!(rangeEnhancerActive || autoGainControlActive)) else $error("compression not exclusive");
	mode_exclusive_a: assert property (!(rangeEnhancerActive && autoGainControlActive))
		else $error("enhancer and agc both active");
	second_write_a: assert property (regWrEn && regAddr == 8'h6c |-> ##2
		{volumeGang, biquadCount, softStepEnable} ==
		{$past(regWrData[7:5], 2), !$past(regWrData[4], 2)}) else $error("write not applied");
	unmapped_read_a: assert property (regRdEn && regAddr != 8'h6b && regAddr != 8'h6c |=>
		regRdData == 8'h00) else $error("unmapped read not zero");
	lock_hold_a: assert property ((runtimeVolumeLock && adcPowered) [*3] |=>
		$stable(firstChannelAppliedCode)) else $error("volume moved while locked");
	gain_map_a: assert property (firstChannelGainHalfDb ==
		$signed({1'b0, firstChannelAppliedCode}) - 9'sd201) else $error("gain map wrong");
	cover property (regWrEn && regAddr == 8'h6c);
	cover property (rangeCompressionActive);
	cover property ((runtimeVolumeLock && adcPowered) [*3]);
endmodule // adc_dsp_config_bank_sva

bind adc_dsp_config_bank adc_dsp_config_bank_sva u_adc_dsp_config_bank_sva (.ref_clk(ref_clk),
	.arst_n(arst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
	.regWrData(regWrData), .regRdData(regRdData), .adcPowered(adcPowered),
	.runtimeVolumeLock(runtimeVolumeLock), .decimationResponse(decimationResponse),
	.decimationOneHot(decimationOneHot), .highpassSelect(highpassSelect),
	.highpassUseIir(highpassUseIir), .volumeGang(volumeGang), .biquadCount(biquadCount),
	.biquadEnable(biquadEnable), .softStepEnable(softStepEnable),
	.rangeEnhancerActive(rangeEnhancerActive), .autoGainControlActive(autoGainControlActive),
	.rangeCompressionActive(rangeCompressionActive),
	.firstChannelAppliedCode(firstChannelAppliedCode),
	.firstChannelGainHalfDb(firstChannelGainHalfDb));

// [verif/adc_dsp_config_bank_test.sv]
module adc_dsp_config_bank_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, arst_n, regWrEn, regRdEn, adcPowered, gainHi;
	logic [7:0] regAddr, regWrData, v1, v2, d0, d1;
	logic [1:0] enh, act;
	logic [2:0] dm;
	logic [15:0] r;
	logic [15:0] lfsr = 16'haae9;
	int nErrors, testsRun;
	wire [7:0] rd, ap1, ap2;
	wire signed [8:0] g1, g2;
	wire [1:0] dec, hp, bq, mute;
	wire [2:0] oh, be;
	wire lock, enhs, sumAvg, iir, gang, ss, range_enhancer, auto_gain_control, range_compression, clip;
	adc_dsp_config_bank u_adc_dsp_config_bank (.ref_clk(ref_clk), .arst_n(arst_n),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(rd), .adcPowered(adcPowered), .firstChannelVolumeCode(v1),
		.secondChannelVolumeCode(v2), .channelActive(act), .channelRangeEnhEnable(enh),
		.channelGainAboveZero(gainHi), .runtimeVolumeLock(lock), .enhancedDynamicsSel(enhs),
		.decimationResponse(dec), .decimationOneHot(oh), .channelSummationAvg(sumAvg),
		.highpassSelect(hp), .highpassUseIir(iir), .volumeGang(gang), .biquadCount(bq),
		.biquadEnable(be), .softStepEnable(ss), .rangeEnhancerActive(range_enhancer),
		.autoGainControlActive(auto_gain_control), .rangeCompressionActive(range_compression), .antiClipEngaged(clip),
		.channelMute(mute), .firstChannelAppliedCode(ap1), .secondChannelAppliedCode(ap2),
		.firstChannelGainHalfDb(g1), .secondChannelGainHalfDb(g2));
	function logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	// expected {compression, enhancer, agc} from the second register and channel enables
	function logic [2:0] modeExp(logic [7:0] c, logic [1:0] e);
		return {c[1], !c[1] && |e && !c[3], !c[1] && |e && c[3]};
	endfunction
	task check(string n, logic [8:0] e, logic [8:0] g);
		testsRun++;
		if (g !== e) begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task printVerdict;
		if (nErrors == 0 && testsRun > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// waits until the field outputs have caught up with the write
	task wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask
	task rdc(logic [7:0] a, logic [7:0] e);
		@(posedge ref_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		@(negedge ref_clk);
		check("readback", e, rd);
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		nErrors++;
		printVerdict;
	end
	initial begin
		arst_n = 1'b0;
		{regWrEn, regRdEn, adcPowered, gainHi} = 4'h0;
		{regAddr, regWrData, enh} = 18'h0;
		v1 = 8'hc9;
		v2 = 8'hc9;
		act = 2'h3;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		rdc(8'h6b, 8'h01);
		rdc(8'h6c, 8'h40);
		check("hpsel", 2'h1, hp);
		rdc(8'h6d, 8'h00);
		wr(8'h6d, 8'hff);
		rdc(8'h6b, 8'h01);
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			// reserved codes and bit two stay clear, the host may not write them
			d0 = {r[7:6], 2'(i % 3), 1'b0, r[2], 2'(i)};
			d1 = {r[15:11], 1'b0, r[9:8]};
			@(posedge ref_clk);
			enh <= r[5:4];
			gainHi <= r[3];
			wr(8'h6b, d0);
			wr(8'h6c, d1);
			check("onehot", 3'h1 << d0[5:4], oh);
			check("deci", d0[5:4], dec);
			check("bq", d1[6:5], bq);
			check("sum", d0[2], sumAvg);
			check("iir", d0[1:0] == 2'h0, iir);
			check("hpsel", d0[1:0], hp);
			check("lockenh", d0[7:6], {lock, enhs});
			check("bqen", 3'h7 >> (2'h3 - d1[6:5]), be);
			check("gangss", {d1[7], !d1[4]}, {gang, ss});
			dm = modeExp(d1, enh);
			check("mode", dm, {range_compression, range_enhancer, auto_gain_control});
			check("clip", d1[0] && gainHi && |dm, clip);
			rdc(8'h6c, d1);
		end
		wr(8'h6b, 8'h01);
		wr(8'h6c, 8'h10);
		@(posedge ref_clk);
		adcPowered <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			@(posedge ref_clk);
			v1 <= (i == 0) ? 8'h00 : r[7:0];
			v2 <= r[15:8];
			act <= 2'(i);
			repeat (3) @(negedge ref_clk);
			check("ap1", v1, ap1);
			check("ap2", v2, ap2);
			check("gain", {1'b0, v1} - 9'd201, g1);
			check("gain2", {1'b0, v2} - 9'd201, g2);
			check("mute", {v2 == 8'h00 || !act[1], v1 == 8'h00 || !act[0]}, mute);
		end
		wr(8'h6c, 8'h90);
		@(posedge ref_clk);
		v1 <= 8'h55;
		repeat (3) @(negedge ref_clk);
		check("gang", 8'h55, ap2);
		wr(8'h6b, 8'h81);
		@(posedge ref_clk);
		v1 <= 8'h20;
		repeat (6) @(negedge ref_clk);
		check("held", 8'h55, ap1);
		@(posedge ref_clk);
		adcPowered <= 1'b0;
		repeat (3) @(negedge ref_clk);
		check("free", 8'h20, ap1);
		wr(8'h6b, 8'h01);
		wr(8'h6c, 8'h00);
		@(posedge ref_clk);
		v1 <= 8'h24;
		repeat (3) @(negedge ref_clk);
		check("stepmid", 8'h21, ap1);
		repeat (4) @(negedge ref_clk);
		check("step", 8'h24, ap1);
		// move the fields off their reset values so the mid-run reset is visible
		wr(8'h6b, 8'h62);
		@(posedge ref_clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		check("rsthp", 2'h1, hp);
		rdc(8'h6b, 8'h01);
		rdc(8'h6c, 8'h40);
		check("rstbq", 3'h3, be);
		printVerdict;
	end
endmodule // adc_dsp_config_bank_test
